// [common/iosd_pkg.sv]
// Purpose: Constants and types for the I/O space decoder
// Assumes: 8-bit data space addresses, one access per clock
// Notes:   Shared by the decoder and its low I/O bank
package iosd_pkg;

  // ----------------------------------------------------------------
  // Access kinds from the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE     = 3'b000,
    OP_IO_IN    = 3'b001,
    OP_IO_OUT   = 3'b010,
    OP_DS_LOAD  = 3'b011,
    OP_DS_STORE = 3'b100,
    OP_BIT_SET  = 3'b101,
    OP_BIT_CLR  = 3'b110,
    OP_BIT_TEST = 3'b111
  } iosd_op_type;

  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_LOW  = 2'b01,
    TGT_TWI  = 2'b10,
    TGT_RESV = 2'b11
  } iosd_tgt_type;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_LAST     = 8'h3F;
  localparam logic [7:0] BIT_LAST    = 8'h1F;
  localparam logic [7:0] DS_IO_BASE  = 8'h20;
  localparam logic [7:0] EXT_BASE    = 8'h60;
  localparam logic [7:0] EXT_LAST    = 8'hFF;
  localparam int         LOW_DEPTH   = 64;

  localparam logic [7:0] TWI_BIT_RATE   = 8'hB8;
  localparam logic [7:0] TWI_STATUS     = 8'hB9;
  localparam logic [7:0] TWI_OWN_ADDR   = 8'hBA;
  localparam logic [7:0] TWI_DATA       = 8'hBB;
  localparam logic [7:0] TWI_CONTROL    = 8'hBC;
  localparam logic [7:0] TWI_ADDR_MASK  = 8'hBD;
  localparam logic [7:0] TWI_HIGH_SPEED = 8'hBE;

  // ----------------------------------------------------------------
  // Low I/O status register with write-one-to-clear flags
  // ----------------------------------------------------------------
  localparam logic [5:0] FLAG_IDX  = 6'h16;
  localparam logic [7:0] FLAG_W1C  = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int         CTRL_INT_BIT  = 7;
  localparam int         CTRL_WCOL_BIT = 3;
  localparam logic [7:0] CTRL_RW_MASK  = 8'h75;
  localparam int         STAT_LSB      = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LOW_RESET  = 8'h00;
  localparam logic [7:0] TWI_RESET  = 8'h00;
  localparam logic [1:0] PS_RESET   = 2'h0;
  localparam logic [6:0] MASK_RESET = 7'h00;

endpackage

// [logic/iosd_low_bank.sv]
// Purpose: Storage for the 64 low I/O locations
// Assumes: At most one write kind per cycle
// Notes:   One location holds hardware-set, write-one-to-clear flags
`timescale 1ns/10ps
module iosd_low_bank (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr,
  input  wire logic       i_bset,
  input  wire logic       i_bclr,
  input  wire logic [5:0] i_idx,
  input  wire logic [2:0] i_bit,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_events,
  output logic      [7:0] o_rd_data,
  output logic      [7:0] o_flags
);

  logic [7:0] mem_q [iosd_pkg::LOW_DEPTH];

  // ----------------------------------------------------------------
  // Next value of one location
  // ----------------------------------------------------------------
  function automatic logic [7:0] f_next(
    input logic [7:0] cur,
    input logic [7:0] w1c
  );
    logic [7:0] one;
    logic [7:0] nxt;
    one = 8'h01 << i_bit;
    nxt = cur;
    if (i_wr)
      nxt = (i_wdata & ~w1c) | (cur & w1c & ~i_wdata);
    else if (i_bset)
      nxt = (cur | (one & ~w1c)) & ~(one & w1c);
    else if (i_bclr)
      nxt = cur & ~(one & ~w1c);
    return nxt;
  endfunction

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < iosd_pkg::LOW_DEPTH; i++)
        mem_q[i] <= iosd_pkg::LOW_RESET;
    end
    else
    begin
      if ((i_wr || i_bset || i_bclr) && i_idx != iosd_pkg::FLAG_IDX)
        mem_q[i_idx] <= f_next(mem_q[i_idx], 8'h00);
      // Hardware set wins over a clear in the same cycle
      if ((i_wr || i_bset || i_bclr) && i_idx == iosd_pkg::FLAG_IDX)
        mem_q[iosd_pkg::FLAG_IDX] <=
          f_next(mem_q[iosd_pkg::FLAG_IDX], iosd_pkg::FLAG_W1C)
          | i_events;
      else
        mem_q[iosd_pkg::FLAG_IDX] <= mem_q[iosd_pkg::FLAG_IDX] | i_events;
    end
  end

  assign o_rd_data = mem_q[i_idx];
  assign o_flags   = mem_q[iosd_pkg::FLAG_IDX];

endmodule

// [logic/iosd_decoder.sv]
// Purpose: I/O space decoder and two-wire interface register map
// Assumes: Core presents one access per cycle on i_op/i_addr
// Notes:   Reads answer one cycle after the request
`timescale 1ns/10ps
module iosd_decoder (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic [2:0] i_op,
  input  wire logic [7:0] i_addr,
  input  wire logic [2:0] i_bit_idx,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_flag_events,
  input  wire logic       i_twi_int,
  input  wire logic [4:0] i_twi_status,
  input  wire logic       i_twi_wcol,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  output logic            o_bit_value,
  output logic            o_refused,
  output logic      [7:0] o_twi_bit_rate,
  output logic      [1:0] o_twi_prescale,
  output logic      [7:0] o_twi_own_addr,
  output logic      [7:0] o_twi_data,
  output logic      [7:0] o_twi_control,
  output logic      [6:0] o_twi_addr_mask,
  output logic            o_twi_high_speed
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic iosd_pkg::iosd_tgt_type f_target(
    input logic [2:0] op,
    input logic [7:0] a
  );
    iosd_pkg::iosd_tgt_type t;
    t = iosd_pkg::TGT_NONE;
    if (op == iosd_pkg::OP_IO_IN || op == iosd_pkg::OP_IO_OUT)
    begin
      if (a <= iosd_pkg::IO_LAST)
        t = iosd_pkg::TGT_LOW;
    end
    else if (op == iosd_pkg::OP_BIT_SET || op == iosd_pkg::OP_BIT_CLR ||
             op == iosd_pkg::OP_BIT_TEST)
    begin
      if (a <= iosd_pkg::BIT_LAST)
        t = iosd_pkg::TGT_LOW;
    end
    else if (op == iosd_pkg::OP_DS_LOAD || op == iosd_pkg::OP_DS_STORE)
    begin
      if (a >= iosd_pkg::EXT_BASE)
      begin
        if (a >= iosd_pkg::TWI_BIT_RATE && a <= iosd_pkg::TWI_HIGH_SPEED)
          t = iosd_pkg::TGT_TWI;
        else
          t = iosd_pkg::TGT_RESV;
      end
      else if (a >= iosd_pkg::DS_IO_BASE)
        t = iosd_pkg::TGT_LOW;
    end
    return t;
  endfunction

  function automatic logic [5:0] f_low_index(
    input logic [2:0] op,
    input logic [7:0] a
  );
    logic [7:0] idx;
    idx = a;
    if (op == iosd_pkg::OP_DS_LOAD || op == iosd_pkg::OP_DS_STORE)
      idx = 8'(a - iosd_pkg::DS_IO_BASE);
    return idx[5:0];
  endfunction

  iosd_pkg::iosd_tgt_type tgt;
  logic [5:0]             low_idx;
  logic                   is_read;
  logic                   is_write;
  logic                   low_wr;
  logic                   low_bset;
  logic                   low_bclr;
  logic                   twi_wr;
  logic [7:0]             low_rd_data;
  logic [7:0]             low_flags;
  logic [7:0]             twi_rd_data;

  assign tgt      = f_target(i_op, i_addr);
  assign low_idx  = f_low_index(i_op, i_addr);
  assign is_read  = i_op == iosd_pkg::OP_IO_IN ||
                    i_op == iosd_pkg::OP_DS_LOAD ||
                    i_op == iosd_pkg::OP_BIT_TEST;
  assign is_write = i_op == iosd_pkg::OP_IO_OUT ||
                    i_op == iosd_pkg::OP_DS_STORE;
  assign low_wr   = is_write && tgt == iosd_pkg::TGT_LOW;
  assign low_bset = i_op == iosd_pkg::OP_BIT_SET &&
                    tgt == iosd_pkg::TGT_LOW;
  assign low_bclr = i_op == iosd_pkg::OP_BIT_CLR &&
                    tgt == iosd_pkg::TGT_LOW;
  assign twi_wr   = is_write && tgt == iosd_pkg::TGT_TWI;

  // ----------------------------------------------------------------
  // Low I/O locations
  // ----------------------------------------------------------------
  iosd_low_bank u_low_bank (
    .i_clock   (i_clock),
    .i_rst_n   (rst_n_q),
    .i_wr      (low_wr),
    .i_bset    (low_bset),
    .i_bclr    (low_bclr),
    .i_idx     (low_idx),
    .i_bit     (i_bit_idx),
    .i_wdata   (i_wdata),
    .i_events  (i_flag_events),
    .o_rd_data (low_rd_data),
    .o_flags   (low_flags)
  );

  // ----------------------------------------------------------------
  // Two-wire interface registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_twi_bit_rate   <= iosd_pkg::TWI_RESET;
      o_twi_prescale   <= iosd_pkg::PS_RESET;
      o_twi_own_addr   <= iosd_pkg::TWI_RESET;
      o_twi_data       <= iosd_pkg::TWI_RESET;
      o_twi_addr_mask  <= iosd_pkg::MASK_RESET;
      o_twi_high_speed <= 1'b0;
    end
    else if (twi_wr)
    begin
      if (i_addr == iosd_pkg::TWI_BIT_RATE)
        o_twi_bit_rate <= i_wdata;
      else if (i_addr == iosd_pkg::TWI_STATUS)
        o_twi_prescale <= i_wdata[1:0];
      else if (i_addr == iosd_pkg::TWI_OWN_ADDR)
        o_twi_own_addr <= i_wdata;
      else if (i_addr == iosd_pkg::TWI_DATA)
        o_twi_data <= i_wdata;
      else if (i_addr == iosd_pkg::TWI_ADDR_MASK)
        o_twi_addr_mask <= i_wdata[7:1];
      else if (i_addr == iosd_pkg::TWI_HIGH_SPEED)
        o_twi_high_speed <= i_wdata[0];
    end
  end

  // Control: interrupt flag is write-one-to-clear, collision is a mirror
  logic ctrl_wr;
  assign ctrl_wr = twi_wr && i_addr == iosd_pkg::TWI_CONTROL;

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      o_twi_control <= iosd_pkg::TWI_RESET;
    else
    begin
      if (ctrl_wr)
        o_twi_control <= (i_wdata & iosd_pkg::CTRL_RW_MASK) |
                         (o_twi_control & ~iosd_pkg::CTRL_RW_MASK);
      // Set wins: an interrupt in the clearing cycle is kept
      o_twi_control[iosd_pkg::CTRL_INT_BIT] <= i_twi_int ||
        (o_twi_control[iosd_pkg::CTRL_INT_BIT] &&
         !(ctrl_wr && i_wdata[iosd_pkg::CTRL_INT_BIT]));
      o_twi_control[iosd_pkg::CTRL_WCOL_BIT] <= i_twi_wcol;
    end
  end

  always_comb
  begin
    twi_rd_data = 8'h00;
    if (i_addr == iosd_pkg::TWI_BIT_RATE)
      twi_rd_data = o_twi_bit_rate;
    else if (i_addr == iosd_pkg::TWI_STATUS)
      twi_rd_data = {i_twi_status, 1'b0, o_twi_prescale};
    else if (i_addr == iosd_pkg::TWI_OWN_ADDR)
      twi_rd_data = o_twi_own_addr;
    else if (i_addr == iosd_pkg::TWI_DATA)
      twi_rd_data = o_twi_data;
    else if (i_addr == iosd_pkg::TWI_CONTROL)
      twi_rd_data = o_twi_control;
    else if (i_addr == iosd_pkg::TWI_ADDR_MASK)
      twi_rd_data = {o_twi_addr_mask, 1'b0};
    else if (i_addr == iosd_pkg::TWI_HIGH_SPEED)
      twi_rd_data = {7'h00, o_twi_high_speed};
  end

  // ----------------------------------------------------------------
  // Answer to the core
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_rdata     <= 8'h00;
      o_rvalid    <= 1'b0;
      o_bit_value <= 1'b0;
      o_refused   <= 1'b0;
    end
    else
    begin
      o_rvalid  <= is_read;
      o_refused <= i_op != iosd_pkg::OP_IDLE &&
                   tgt == iosd_pkg::TGT_NONE;
      if (is_read && tgt == iosd_pkg::TGT_LOW)
        o_rdata <= low_rd_data;
      else if (is_read && tgt == iosd_pkg::TGT_TWI)
        o_rdata <= twi_rd_data;
      else if (is_read)
        o_rdata <= 8'h00;
      o_bit_value <= i_op == iosd_pkg::OP_BIT_TEST &&
                     tgt == iosd_pkg::TGT_LOW &&
                     low_rd_data[i_bit_idx];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!rst_n_q);

  chk_bit_range: assert property (
    (i_op == iosd_pkg::OP_BIT_SET || i_op == iosd_pkg::OP_BIT_CLR) &&
    i_addr > iosd_pkg::BIT_LAST && i_flag_events == 8'h00
    |=> o_refused && $stable(low_flags))
    else $error("bit write accepted outside bit range");

  chk_bit_test: assert property (
    i_op == iosd_pkg::OP_BIT_TEST && i_addr <= iosd_pkg::BIT_LAST
    |=> o_rvalid && o_bit_value == $past(low_rd_data[i_bit_idx]))
    else $error("bit test value wrong");

  chk_w1c_clear: assert property (
    ctrl_wr && i_wdata[iosd_pkg::CTRL_INT_BIT] && !i_twi_int
    |=> !o_twi_control[iosd_pkg::CTRL_INT_BIT])
    else $error("interrupt flag not cleared by one");

  chk_w1c_keep: assert property (
    o_twi_control[iosd_pkg::CTRL_INT_BIT] &&
    !(ctrl_wr && i_wdata[iosd_pkg::CTRL_INT_BIT])
    |=> o_twi_control[iosd_pkg::CTRL_INT_BIT])
    else $error("interrupt flag lost");

  chk_set_wins: assert property (
    i_twi_int ##1 1'b1 |-> o_twi_control[iosd_pkg::CTRL_INT_BIT])
    else $error("interrupt lost in clearing cycle");

  chk_bit_isolate: assert property (
    (low_bset || low_bclr) && low_idx == iosd_pkg::FLAG_IDX &&
    i_flag_events == 8'h00
    |=> (low_flags | (8'h01 << $past(i_bit_idx))) ==
        ($past(low_flags) | (8'h01 << $past(i_bit_idx))))
    else $error("bit op disturbed other flags");

  chk_io_range: assert property (
    (i_op == iosd_pkg::OP_IO_IN || i_op == iosd_pkg::OP_IO_OUT) &&
    i_addr > iosd_pkg::IO_LAST |=> o_refused ##0 $stable(o_twi_bit_rate))
    else $error("direct I/O accepted beyond 0x3F");

  chk_ds_alias: assert property (
    (i_op == iosd_pkg::OP_IO_OUT && i_addr <= iosd_pkg::IO_LAST &&
     i_addr[5:0] != iosd_pkg::FLAG_IDX) ##1
    (i_op == iosd_pkg::OP_DS_LOAD &&
     i_addr == 8'($past(i_addr) + iosd_pkg::DS_IO_BASE))
    |=> o_rdata == $past(i_wdata, 2))
    else $error("data-space alias mismatch");

  chk_ext_store: assert property (
    i_op == iosd_pkg::OP_DS_STORE && i_addr == iosd_pkg::TWI_BIT_RATE
    |=> o_twi_bit_rate == $past(i_wdata))
    else $error("extended store lost");

  chk_resv_zero: assert property (
    i_op == iosd_pkg::OP_DS_LOAD && tgt == iosd_pkg::TGT_RESV
    |=> o_rvalid && o_rdata == 8'h00)
    else $error("reserved read not zero");

  cov_bit_clear_flag: cover property (
    low_bset && low_idx == iosd_pkg::FLAG_IDX && low_flags != 8'h00);
  cov_ds_twi_read: cover property (
    i_op == iosd_pkg::OP_DS_LOAD && tgt == iosd_pkg::TGT_TWI);
  cov_int_clear: cover property (
    ctrl_wr && i_wdata[iosd_pkg::CTRL_INT_BIT] &&
    o_twi_control[iosd_pkg::CTRL_INT_BIT]);
  cov_refused: cover property (o_refused);

endmodule

// [test/iosd_core_model.sv]
// Purpose: Core-side model issuing accesses to the decoder
// Assumes: One access at a time, answer read at the fall half a cycle after it is taken
// Notes:   Idle address and data lines carry the inverse of the last value
`timescale 1ns/10ps
module iosd_core_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  input  wire logic       i_bit_value,
  input  wire logic       i_refused,
  output logic      [2:0] o_op,
  output logic      [7:0] o_addr,
  output logic      [2:0] o_bit_idx,
  output logic      [7:0] o_wdata
);
  logic [7:0] got_data;
  logic       got_valid;
  logic       got_bit;
  logic       got_refused;

  initial
  begin
    o_op      = 3'h0;
    o_addr    = 8'h00;
    o_bit_idx = 3'h0;
    o_wdata   = 8'h00;
  end

  // --------------------------------------------------------------
  // Access: driven after a fall, taken at the next rise
  // --------------------------------------------------------------
  task automatic issue(
    input logic [2:0] op,
    input logic [7:0] addr,
    input logic [2:0] bidx,
    input logic [7:0] wd
  );
    @(negedge i_clock);
    o_op      = op;
    o_addr    = addr;
    o_bit_idx = bidx;
    o_wdata   = wd;
    @(negedge i_clock);
    got_data    = i_rdata;
    got_valid   = i_rvalid;
    got_bit     = i_bit_value;
    got_refused = i_refused;
    o_op        = 3'h0;
    // Released lines must not keep looking valid
    o_addr      = ~addr;
    o_bit_idx   = ~bidx;
    o_wdata     = ~wd;
  endtask

  task automatic ds_io(
    input logic [2:0] op,
    input logic [7:0] io_addr,
    input logic [7:0] wd
  );
    issue(op, io_addr + iosd_pkg::DS_IO_BASE, 3'h0, wd);
  endtask

  // --------------------------------------------------------------
  // Store then alias load on back-to-back edges, no idle between
  // --------------------------------------------------------------
  task automatic out_then_load(
    input logic [7:0] io_addr,
    input logic [7:0] wd
  );
    @(negedge i_clock);
    o_op      = iosd_pkg::OP_IO_OUT;
    o_addr    = io_addr;
    o_bit_idx = 3'h0;
    o_wdata   = wd;
    @(negedge i_clock);
    o_op      = iosd_pkg::OP_DS_LOAD;
    o_addr    = io_addr + iosd_pkg::DS_IO_BASE;
    @(negedge i_clock);
    got_data    = i_rdata;
    got_valid   = i_rvalid;
    got_bit     = i_bit_value;
    got_refused = i_refused;
    o_op        = 3'h0;
    o_addr      = ~o_addr;
    o_bit_idx   = 3'h7;
    o_wdata     = ~wd;
  endtask
endmodule

// [test/tb_iosd_decoder.sv]
// Purpose: Self-checking bench for the I/O space decoder
// Assumes: Inputs change on the falling edge
// Notes:   Each scenario is one task that judges its own results
`timescale 1ns/10ps
module tb_iosd_decoder;
  logic       clock;
  logic       rst_n;
  logic [7:0] flag_events;
  logic       twi_int;
  logic [4:0] twi_status;
  logic       twi_wcol;
  wire  [2:0] op;
  wire  [7:0] addr;
  wire  [2:0] bit_idx;
  wire  [7:0] wdata;
  wire  [7:0] rdata;
  wire        rvalid;
  wire        bit_value;
  wire        refused;
  wire  [7:0] bit_rate;
  wire  [1:0] prescale;
  wire  [7:0] own_addr;
  wire  [7:0] twi_data;
  wire  [7:0] control;
  wire  [6:0] addr_mask;
  wire        high_speed;
  int         miscompares;
  int         comparisons;

  iosd_decoder i_iosd_decoder (
    .i_clock          (clock),
    .i_rst_n          (rst_n),
    .i_op             (op),
    .i_addr           (addr),
    .i_bit_idx        (bit_idx),
    .i_wdata          (wdata),
    .i_flag_events    (flag_events),
    .i_twi_int        (twi_int),
    .i_twi_status     (twi_status),
    .i_twi_wcol       (twi_wcol),
    .o_rdata          (rdata),
    .o_rvalid         (rvalid),
    .o_bit_value      (bit_value),
    .o_refused        (refused),
    .o_twi_bit_rate   (bit_rate),
    .o_twi_prescale   (prescale),
    .o_twi_own_addr   (own_addr),
    .o_twi_data       (twi_data),
    .o_twi_control    (control),
    .o_twi_addr_mask  (addr_mask),
    .o_twi_high_speed (high_speed)
  );

  iosd_core_model i_iosd_core_model (
    .i_clock     (clock),
    .i_rdata     (rdata),
    .i_rvalid    (rvalid),
    .i_bit_value (bit_value),
    .i_refused   (refused),
    .o_op        (op),
    .o_addr      (addr),
    .o_bit_idx   (bit_idx),
    .o_wdata     (wdata)
  );

  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read through the core model, checking data, valid and refusal
  task automatic rd(input logic [2:0] o, input logic [7:0] a,
                    input logic [7:0] exp, input logic ref_exp);
    i_iosd_core_model.issue(o, a, 3'h0, 8'h00);
    chk8(i_iosd_core_model.got_data, exp, "read data");
    chk8({7'h00, i_iosd_core_model.got_valid}, 8'h01, "read valid");
    chk8({7'h00, i_iosd_core_model.got_refused}, {7'h00, ref_exp},
         "refusal");
  endtask

  task automatic pulse(input logic [7:0] ev, input logic ti);
    @(negedge clock);
    flag_events = ev;
    twi_int     = ti;
    @(negedge clock);
    flag_events = 8'h00;
    twi_int     = 1'b0;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    for (int k = 0; k < 7; k++)
      rd(iosd_pkg::OP_DS_LOAD, 8'hB8 + 8'(k), 8'h00, 1'b0);
    chk8(control, 8'h00, "control after reset");
  endtask

  task automatic t_io_map;
    i_iosd_core_model.issue(iosd_pkg::OP_IO_OUT, 8'h10, 3'h0, 8'hAA);
    rd(iosd_pkg::OP_DS_LOAD, 8'h30, 8'hAA, 1'b0);
    i_iosd_core_model.ds_io(iosd_pkg::OP_DS_STORE, 8'h3F, 8'h5A);
    rd(iosd_pkg::OP_IO_IN, 8'h3F, 8'h5A, 1'b0);
    rd(iosd_pkg::OP_IO_IN, 8'h40, 8'h00, 1'b1);
    rd(iosd_pkg::OP_DS_LOAD, 8'h1F, 8'h00, 1'b1);
    i_iosd_core_model.out_then_load(8'h11, 8'h96);
    chk8(i_iosd_core_model.got_data, 8'h96, "alias load");
  endtask

  task automatic t_ext;
    logic [7:0] a [6] = '{8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE};
    logic [7:0] e [6] = '{8'hAB, 8'hFF, 8'hFF, 8'h75, 8'hFE, 8'h01};
    twi_status = 5'h15;
    i_iosd_core_model.issue(iosd_pkg::OP_DS_STORE, 8'hB8, 3'h0, 8'h55);
    chk8(bit_rate, 8'h55, "bit rate");
    i_iosd_core_model.issue(iosd_pkg::OP_IO_OUT, 8'hB8, 3'h0, 8'hAA);
    chk8({7'h00, i_iosd_core_model.got_refused}, 8'h01, "refused");
    chk8({7'h00, i_iosd_core_model.got_valid}, 8'h00, "no valid");
    chk8(bit_rate, 8'h55, "bit rate kept");
    for (int k = 0; k < 6; k++)
    begin
      i_iosd_core_model.issue(iosd_pkg::OP_DS_STORE, a[k], 3'h0, 8'hFF);
      rd(iosd_pkg::OP_DS_LOAD, a[k], e[k], 1'b0);
    end
    chk8({prescale, high_speed, addr_mask[6:2]}, 8'hFF, "fields");
    chk8(own_addr, 8'hFF, "own address");
    chk8(twi_data, 8'hFF, "data register");
  endtask

  task automatic t_reserved;
    logic [7:0] a [5] = '{8'h60, 8'hB7, 8'hBF, 8'hC0, 8'hFF};
    for (int k = 0; k < 5; k++)
    begin
      i_iosd_core_model.issue(iosd_pkg::OP_DS_STORE, a[k], 3'h0, 8'hA5);
      chk8({7'h00, i_iosd_core_model.got_refused}, 8'h00, "refusal");
      chk8(bit_rate, 8'h55, "bit rate untouched");
      chk8(twi_data, 8'hFF, "data untouched");
      rd(iosd_pkg::OP_DS_LOAD, a[k], 8'h00, 1'b0);
    end
  endtask

  task automatic t_bits;
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_SET, 8'h05, 3'h3, 8'h00);
    rd(iosd_pkg::OP_IO_IN, 8'h05, 8'h08, 1'b0);
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_TEST, 8'h05, 3'h3, 8'h00);
    chk8({7'h00, i_iosd_core_model.got_bit}, 8'h01, "bit test");
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_TEST, 8'h05, 3'h2, 8'h00);
    chk8({7'h00, i_iosd_core_model.got_bit}, 8'h00, "bit test");
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_CLR, 8'h05, 3'h3, 8'h00);
    rd(iosd_pkg::OP_IO_IN, 8'h05, 8'h00, 1'b0);
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_SET, 8'h1F, 3'h7, 8'h00);
    rd(iosd_pkg::OP_IO_IN, 8'h1F, 8'h80, 1'b0);
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_SET, 8'h20, 3'h0, 8'h00);
    chk8({7'h00, i_iosd_core_model.got_refused}, 8'h01, "refused");
    rd(iosd_pkg::OP_IO_IN, 8'h20, 8'h00, 1'b0);
  endtask

  task automatic t_flags;
    pulse(8'h0F, 1'b0);
    rd(iosd_pkg::OP_IO_IN, 8'h16, 8'h0F, 1'b0);
    i_iosd_core_model.issue(iosd_pkg::OP_IO_OUT, 8'h16, 3'h0, 8'h01);
    rd(iosd_pkg::OP_IO_IN, 8'h16, 8'h0E, 1'b0);
    i_iosd_core_model.issue(iosd_pkg::OP_IO_OUT, 8'h16, 3'h0, 8'h00);
    rd(iosd_pkg::OP_IO_IN, 8'h16, 8'h0E, 1'b0);
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_SET, 8'h16, 3'h1, 8'h00);
    rd(iosd_pkg::OP_IO_IN, 8'h16, 8'h0C, 1'b0);
    i_iosd_core_model.issue(iosd_pkg::OP_BIT_CLR, 8'h16, 3'h2, 8'h00);
    rd(iosd_pkg::OP_IO_IN, 8'h16, 8'h0C, 1'b0);
    pulse(8'h00, 1'b1);
    i_iosd_core_model.issue(iosd_pkg::OP_DS_STORE, 8'hBC, 3'h0, 8'h00);
    chk8(control, 8'h80, "control flag kept");
    twi_wcol = 1'b1;
    i_iosd_core_model.issue(iosd_pkg::OP_DS_STORE, 8'hBC, 3'h0, 8'h80);
    chk8(control, 8'h08, "control flag cleared");
    // Event and clearing write on the same edge: the event must win
    fork
      pulse(8'h00, 1'b1);
      i_iosd_core_model.issue(iosd_pkg::OP_DS_STORE, 8'hBC, 3'h0, 8'h80);
    join
    chk8(control, 8'h88, "set wins over clear");
    fork
      pulse(8'h04, 1'b0);
      i_iosd_core_model.issue(iosd_pkg::OP_IO_OUT, 8'h16, 3'h0, 8'h04);
    join
    rd(iosd_pkg::OP_IO_IN, 8'h16, 8'h0C, 1'b0);
  endtask

  // --------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial
  begin
    rst_n       = 1'b0;
    flag_events = 8'h00;
    twi_int     = 1'b0;
    twi_status  = 5'h00;
    twi_wcol    = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_io_map();
    t_ext();
    t_reserved();
    t_bits();
    t_flags();
    print_verdict();
  end

  initial
  begin
    // Roughly eighteen times the expected length of the run
    #100000;
    miscompares++;
    $display("mismatch at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule
